// ===== fss_pkg.sv
// Package of constants and types for the fail-safe supply supervisor
package fss_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // Timing figures in microseconds
   localparam longint unsigned BUS_IDLE_US = 64'd8_000_000;
   localparam longint unsigned WD_PERIOD_US = 64'd256_000;
   localparam longint unsigned RST_PULSE_US = 64'd1_000;
   localparam longint unsigned BUS_IDLE_CYC = BUS_IDLE_US * CLK_HZ / 64'd1_000_000;
   localparam longint unsigned WD_PERIOD_CYC = WD_PERIOD_US * CLK_HZ / 64'd1_000_000;
   localparam longint unsigned RST_PULSE_CYC = RST_PULSE_US * CLK_HZ / 64'd1_000_000;
   localparam int unsigned WD_FAIL_LIMIT = 8;
   localparam int unsigned HOLD_BIT = 0;
   localparam int unsigned SAFE_SEL_BIT = 4;
   localparam logic [15:0] CMD_RELEASE_A = 16'hDD00;
   localparam logic [15:0] CMD_RELEASE_B = 16'hDD80;
   localparam logic [2:0] OVR_KEEP = 3'h7;
   localparam logic [2:0] OVR_CUT_IDLE = 3'h6;
   localparam logic [2:0] OVR_CUT_LOW = 3'h5;
   localparam logic [2:0] OVR_CUT_BOTH = 3'h4;
   // Resistor classification codes from the comparators
   localparam logic [1:0] RES_KEEP = 2'h0;
   localparam logic [1:0] RES_CUT_IDLE = 2'h1;
   localparam logic [1:0] RES_CUT_LOW = 2'h2;
   localparam logic [1:0] RES_CUT_BOTH = 2'h3;

   typedef enum logic [3:0]
   {
      FSS_KEEP = 4'b0001,
      FSS_CUT_IDLE = 4'b0010,
      FSS_CUT_LOW = 4'b0100,
      FSS_CUT_BOTH = 4'b1000
   } fss_behav_e;

   typedef enum logic [4:0]
   {
      FSS_ST_INIT = 5'b00001,
      FSS_ST_RESET = 5'b00010,
      FSS_ST_NORMAL = 5'b00100,
      FSS_ST_SAFE_ON = 5'b01000,
      FSS_ST_SAFE_OFF = 5'b10000
   } fss_state_e;
endpackage

// ===== fss_timer_if.sv
// Interface carrying the start/expire handshake of a timer
interface fss_timer_if;
   logic run;
   logic expired;
   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface

// ===== fss_timer.sv
// Cycle counter that flags expiry after a set count while run stays high
module fss_timer #(
   parameter longint unsigned COUNT = 64'd10
) (
   input wire logic clk,
   input wire logic rstN,
   fss_timer_if.timer tif
);
   import fss_pkg::*;
   logic [39:0] cnt_reg;
   logic expired_reg;

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         cnt_reg <= 40'h00_0000_0000;
         expired_reg <= 1'b0;
      end
      else if (!tif.run)
      begin
         cnt_reg <= 40'h00_0000_0000;
         expired_reg <= 1'b0;
      end
      else if (cnt_reg >= 40'(COUNT - 64'd1))
         expired_reg <= 1'b1;
      else
         cnt_reg <= cnt_reg + 40'h00_0000_0001;
   end

   assign tif.expired = expired_reg;
endmodule

// ===== fail_safe_supply_supervisor.sv
// Supply sequencing and fail-safe state machine of the supervisor
import fss_pkg::*;
//
// Function
// RULE1 - Hold bit resets to 0; clear: supply on once battery above start threshold.
// RULE2 - Hold clear: supply stays on in ramp down until undervoltage forces reset.
// RULE3 - Hold clear: in reset with battery below start threshold, supply off.
// RULE4 - Hold set (bit 0): supply stays on until power-on reset, battery-fail set.
// RULE5 - Wake-up ending safe state resumes operation in reset mode.
// RULE6 - Safe output driven low while safe mode is active.
// RULE7 - Keep-supply behaviour holds supply on until failure recovers.
// RULE8 - Cutting behaviours monitor bus idle, input one or both, then cut supply.
// RULE9 - Resistor behaviour latched at init-to-normal, used unless overridden.
// RULE10 - Override field: 111 keep, 110 idle, 101 input low, 100 both.
// RULE11 - Cut-on-bus-idle: supply off 8.0 s after bus goes idle.
// RULE12 - Cut-on-input-low: supply off when input one is low.
// RULE13 - Cut-on-both: supply off only after 8.0 s idle and input one low.
// RULE14 - Safe output stays low after wake-up until release command received.
// RULE15 - Input wake-up in supply-off state only if enabled before safe entry.
// RULE16 - Watchdog failure activates safe on first or second reset pulse, bit 4.
// RULE17 - Supply below reset threshold drives safe low together with reset.
// RULE18 - Reset line clamped low externally enters safe mode.
// RULE19 - Eight consecutive missing refreshes declare watchdog failure state.
// RULE20 - No refresh: 1.0 ms reset pulse every 256 ms.
// RULE21 - Recovery needs reset-low released, supply-low released and a valid refresh.
// RULE22 - Wake-up sources: CAN, LIN, or input one high when enabled.
// RULE23 - Resistor code is two bits, valid only at init-to-normal transition.
// RULE24 - Override persists until next power-on reset.
module fail_safe_supply_supervisor #(
   parameter longint unsigned BUS_IDLE_CYCLES = fss_pkg::BUS_IDLE_CYC,
   parameter longint unsigned WD_PERIOD_CYCLES = fss_pkg::WD_PERIOD_CYC,
   parameter longint unsigned RST_PULSE_CYCLES = fss_pkg::RST_PULSE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic batterySupplyOneAboveStart,
   input wire logic mcuSupplyUnderVoltage,
   input wire logic powerOnReset,
   input wire logic initToNormal,
   input wire logic [1:0] debugResistorPinCode,
   input wire logic holdBitWrite,
   input wire logic holdBitValue,
   input wire logic safeSelBitWrite,
   input wire logic safeSelBitValue,
   input wire logic overrideWrite,
   input wire logic [2:0] overrideValue,
   input wire logic inputWakeEnable,
   input wire logic spiCmdValid,
   input wire logic [15:0] spiCmd,
   input wire logic watchdogRefresh,
   input wire logic canBusIdle,
   input wire logic canActivity,
   input wire logic linActivity,
   input wire logic inputOne,
   input wire logic resetPinIn,
   output logic mcuSupplyEnable,
   output logic resetOutN,
   output logic safeOutN,
   output logic batteryFailFlag,
   output logic holdBit,
   output logic [2:0] safeBehaviourCode,
   output logic watchdogFailState
);
   import fss_pkg::*;

   logic rstSync1, rstSync2;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end
      else
      begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   // Pin inputs: three stages, change accepted when stages two and three agree
   logic [2:0] inOneSync, rstPinSync;
   logic inOneLvl_reg, rstPinLvl_reg;
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         inOneSync <= 3'h7;
         rstPinSync <= 3'h7;
         inOneLvl_reg <= 1'b1;
         rstPinLvl_reg <= 1'b1;
      end
      else
      begin
         inOneSync <= {inOneSync[1:0], inputOne};
         rstPinSync <= {rstPinSync[1:0], resetPinIn};
         if (inOneSync[1] == inOneSync[2])
            inOneLvl_reg <= inOneSync[2];
         if (rstPinSync[1] == rstPinSync[2])
            rstPinLvl_reg <= rstPinSync[2];
      end
   end

   fss_state_e state_reg;
   logic holdBit_reg, safeSel_reg, ovrValid_reg, safeLow_reg, battery_fail_flag_reg;
   logic wakeEnLatched_reg, resetDrive_reg, wdFail_reg, firstPulseSeen_reg, pulseActive_reg;
   logic [2:0] ovr_reg;
   logic [1:0] resCode_reg;
   logic [3:0] wdMissCnt_reg, drvHist_reg;
   logic [39:0] wdCnt_reg, pulseCnt_reg;
   logic pulseStart, pulseEnd, releaseCmd, clampedLow, wakeEvent, cutCond;
   fss_behav_e behav;

   // Configuration bits; power-on reset returns all but the latched resistor code to defaults
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         holdBit_reg <= 1'b0; // see RULE1
         safeSel_reg <= 1'b0;
         ovrValid_reg <= 1'b0;
         ovr_reg <= 3'h0;
         resCode_reg <= RES_KEEP;
      end
      else if (powerOnReset)
      begin
         holdBit_reg <= 1'b0;
         safeSel_reg <= 1'b0;
         ovrValid_reg <= 1'b0; // see RULE24
         ovr_reg <= 3'h0;
      end
      else
      begin
         if (holdBitWrite)
            holdBit_reg <= holdBitValue; // see RULE4
         if (safeSelBitWrite)
            safeSel_reg <= safeSelBitValue; // see RULE16
         if (overrideWrite && overrideValue[2])
         begin
            ovr_reg <= overrideValue; // see RULE10
            ovrValid_reg <= 1'b1;
         end
         if (initToNormal && state_reg == FSS_ST_INIT)
            resCode_reg <= debugResistorPinCode; // see RULE9, RULE23
      end
   end

   // Override wins over the latched resistor code
   always_comb
   begin
      behav = FSS_KEEP;
      if (ovrValid_reg) // see RULE10
      begin
         unique case (ovr_reg)
            OVR_CUT_IDLE: behav = FSS_CUT_IDLE;
            OVR_CUT_LOW: behav = FSS_CUT_LOW;
            OVR_CUT_BOTH: behav = FSS_CUT_BOTH;
            default: behav = FSS_KEEP;
         endcase
      end
      else
      begin
         unique case (resCode_reg) // see RULE9
            RES_CUT_IDLE: behav = FSS_CUT_IDLE;
            RES_CUT_LOW: behav = FSS_CUT_LOW;
            RES_CUT_BOTH: behav = FSS_CUT_BOTH;
            default: behav = FSS_KEEP;
         endcase
      end
   end

   // Bus idle timer in its own module so its count can be shortened
   fss_timer_if idleIf ();
   assign idleIf.run = canBusIdle && (state_reg == FSS_ST_SAFE_ON);
   fss_timer #(.COUNT(BUS_IDLE_CYCLES)) idleTimer (
      .clk(clk),
      .rstN(rstSync2),
      .tif(idleIf)
   );

   always_comb
   begin
      unique case (behav)
         FSS_CUT_IDLE: cutCond = idleIf.expired; // see RULE11
         FSS_CUT_LOW: cutCond = !inOneLvl_reg; // see RULE12
         FSS_CUT_BOTH: cutCond = idleIf.expired && !inOneLvl_reg; // see RULE13
         default: cutCond = 1'b0; // see RULE7
      endcase
   end

   // Watchdog period and reset pulse generation
   assign pulseStart = (wdCnt_reg == 40'(WD_PERIOD_CYCLES - 64'd1));
   assign pulseEnd = pulseActive_reg && (pulseCnt_reg == 40'(RST_PULSE_CYCLES - 64'd1));
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
         wdCnt_reg <= 40'h00_0000_0000;
      else if (watchdogRefresh || (state_reg != FSS_ST_NORMAL && state_reg != FSS_ST_INIT
               && state_reg != FSS_ST_RESET) || pulseStart)
         wdCnt_reg <= 40'h00_0000_0000;
      else
         wdCnt_reg <= wdCnt_reg + 40'h00_0000_0001;
   end

   // Reset pulse stands for its width then releases; a refresh does not cut it short
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         pulseActive_reg <= 1'b0;
         pulseCnt_reg <= 40'h00_0000_0000;
      end
      else if (pulseStart)
      begin
         pulseActive_reg <= 1'b1; // see RULE20
         pulseCnt_reg <= 40'h00_0000_0000;
      end
      else if (pulseActive_reg)
      begin
         if (pulseEnd)
            pulseActive_reg <= 1'b0;
         else
            pulseCnt_reg <= pulseCnt_reg + 40'h00_0000_0001;
      end
   end

   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         wdMissCnt_reg <= 4'h0;
         wdFail_reg <= 1'b0;
         firstPulseSeen_reg <= 1'b0;
      end
      else if (watchdogRefresh)
      begin
         wdMissCnt_reg <= 4'h0;
         firstPulseSeen_reg <= 1'b0;
         if (!rstPinLvl_reg == 1'b0 && !mcuSupplyUnderVoltage)
            wdFail_reg <= 1'b0; // see RULE21
      end
      else if (pulseStart)
      begin
         firstPulseSeen_reg <= 1'b1;
         if (wdMissCnt_reg == 4'(WD_FAIL_LIMIT - 1))
            wdFail_reg <= 1'b1; // see RULE19
         else
            wdMissCnt_reg <= wdMissCnt_reg + 4'h1;
      end
   end

   // Clamped reset: line low although released long enough to pass the synchroniser
   assign clampedLow = !rstPinLvl_reg && resetDrive_reg && (&drvHist_reg)
                       && !pulseActive_reg; // see RULE18
   assign releaseCmd = spiCmdValid && (spiCmd == CMD_RELEASE_A || spiCmd == CMD_RELEASE_B);
   assign wakeEvent = canActivity || linActivity
                      || (wakeEnLatched_reg && inOneLvl_reg); // see RULE15, RULE22

   // Safe output: set wins over release
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
         safeLow_reg <= 1'b0;
      else if (mcuSupplyUnderVoltage) // see RULE17
         safeLow_reg <= 1'b1;
      else if (pulseStart && (!safeSel_reg || firstPulseSeen_reg)) // see RULE16
         safeLow_reg <= 1'b1;
      else if (clampedLow || wdFail_reg)
         safeLow_reg <= 1'b1;
      else if (releaseCmd && state_reg != FSS_ST_SAFE_OFF)
         safeLow_reg <= 1'b0; // see RULE14
   end

   // Main mode machine
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         state_reg <= FSS_ST_INIT;
         wakeEnLatched_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            FSS_ST_INIT:
               if (mcuSupplyUnderVoltage)
                  state_reg <= FSS_ST_RESET;
               else if (initToNormal)
                  state_reg <= FSS_ST_NORMAL;
            FSS_ST_RESET:
               if (!mcuSupplyUnderVoltage && !pulseActive_reg)
                  state_reg <= FSS_ST_NORMAL;
            FSS_ST_NORMAL:
            begin
               wakeEnLatched_reg <= inputWakeEnable; // see RULE15
               if (wdFail_reg || clampedLow)
                  state_reg <= FSS_ST_SAFE_ON;
               else if (mcuSupplyUnderVoltage) // see RULE2
                  state_reg <= FSS_ST_RESET;
            end
            FSS_ST_SAFE_ON:
               if (!wdFail_reg && !clampedLow && !mcuSupplyUnderVoltage)
                  state_reg <= FSS_ST_NORMAL; // see RULE21
               else if (cutCond) // see RULE8
                  state_reg <= FSS_ST_SAFE_OFF;
            FSS_ST_SAFE_OFF:
               if (wakeEvent)
                  state_reg <= FSS_ST_RESET; // see RULE5
            default:
               state_reg <= FSS_ST_INIT;
         endcase
      end
   end

   // Supply enable and battery-fail flag
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         mcuSupplyEnable <= 1'b0;
         battery_fail_flag_reg <= 1'b0;
      end
      else
      begin
         if (powerOnReset)
            battery_fail_flag_reg <= 1'b1; // see RULE4
         if (state_reg == FSS_ST_SAFE_OFF)
            mcuSupplyEnable <= 1'b0; // see RULE8
         else if (holdBit_reg)
            mcuSupplyEnable <= !(powerOnReset || battery_fail_flag_reg); // see RULE4
         else if (batterySupplyOneAboveStart)
            mcuSupplyEnable <= 1'b1; // see RULE1
         else if (state_reg == FSS_ST_RESET)
            mcuSupplyEnable <= 1'b0; // see RULE3
      end
   end

   // Reset output low in reset mode and during watchdog pulses
   always_ff @(posedge clk or negedge rstSync2)
   begin
      if (!rstSync2)
      begin
         resetDrive_reg <= 1'b0;
         drvHist_reg <= 4'h0;
      end
      else
      begin
         resetDrive_reg <= !(mcuSupplyUnderVoltage || pulseStart || (pulseActive_reg && !pulseEnd)
                             || state_reg == FSS_ST_RESET || state_reg == FSS_ST_SAFE_OFF);
         drvHist_reg <= {drvHist_reg[2:0], resetDrive_reg};
      end
   end

   assign resetOutN = resetDrive_reg;
   assign safeOutN = !safeLow_reg; // see RULE6
   assign batteryFailFlag = battery_fail_flag_reg;
   assign holdBit = holdBit_reg;
   assign watchdogFailState = wdFail_reg;
   always_comb
   begin
      unique case (behav)
         FSS_CUT_IDLE: safeBehaviourCode = OVR_CUT_IDLE;
         FSS_CUT_LOW: safeBehaviourCode = OVR_CUT_LOW;
         FSS_CUT_BOTH: safeBehaviourCode = OVR_CUT_BOTH;
         default: safeBehaviourCode = OVR_KEEP;
      endcase
   end
endmodule

// ===== fss_monitor.sv
// Checker of supervisor relations seen at the top-level ports
module fss_monitor (
   input wire logic clk,
   input wire logic rstn,
   input wire logic powerOnReset,
   input wire logic initToNormal,
   input wire logic holdBitWrite,
   input wire logic holdBitValue,
   input wire logic overrideWrite,
   input wire logic [2:0] overrideValue,
   input wire logic mcuSupplyUnderVoltage,
   input wire logic spiCmdValid,
   input wire logic [15:0] spiCmd,
   input wire logic resetOutN,
   input wire logic safeOutN,
   input wire logic batteryFailFlag,
   input wire logic holdBit,
   input wire logic [2:0] safeBehaviourCode,
   input wire logic watchdogFailState
);
   import fss_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   property p_hold_por;
      powerOnReset && !holdBitWrite |=> !holdBit && batteryFailFlag;
   endproperty
   a_hold_por: assert property (p_hold_por)
      else $error("hold bit or fail flag wrong after power-on reset");
   property p_hold_wr;
      holdBitWrite && !powerOnReset |=> holdBit == $past(holdBitValue);
   endproperty
   a_hold_wr: assert property (p_hold_wr)
      else $error("hold bit did not take the written value");
   property p_ovr_wr;
      overrideWrite && overrideValue[2] && !powerOnReset |=>
         safeBehaviourCode == $past(overrideValue);
   endproperty
   a_ovr_wr: assert property (p_ovr_wr)
      else $error("override not applied");
   property p_code_set;
      overrideWrite && !overrideValue[2] && !powerOnReset && !initToNormal |=>
         $stable(safeBehaviourCode);
   endproperty
   a_code_set: assert property (p_code_set)
      else $error("refused override changed the behaviour code");
   property p_uv;
      mcuSupplyUnderVoltage |=> !resetOutN && !safeOutN;
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage did not drive reset and safe low together");
   property p_release;
      $rose(safeOutN) |-> $past(spiCmdValid) &&
         ($past(spiCmd) == CMD_RELEASE_A || $past(spiCmd) == CMD_RELEASE_B);
   endproperty
   a_release: assert property (p_release)
      else $error("safe output released without a release command");
   property p_hold_low;
      !safeOutN && !spiCmdValid |=> !safeOutN;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("safe output left low without a command");
   property p_wdfail;
      $rose(watchdogFailState) |-> !safeOutN;
   endproperty
   a_wdfail: assert property (p_wdfail)
      else $error("watchdog failure state without safe output");
endmodule

bind fail_safe_supply_supervisor fss_monitor mon (
   .clk, .rstn, .powerOnReset, .initToNormal, .holdBitWrite, .holdBitValue, .overrideWrite,
   .overrideValue, .mcuSupplyUnderVoltage, .spiCmdValid, .spiCmd, .resetOutN,
   .safeOutN, .batteryFailFlag, .holdBit, .safeBehaviourCode, .watchdogFailState
);

// ===== fss_mcu_model.sv
// Host controller model: watchdog refresh and the reset line
module fss_mcu_model (
   input wire logic clk,
   input wire logic resetOutN,
   input wire logic refreshEn,
   input wire logic clampReset,
   output logic watchdogRefresh,
   output logic resetPinIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] gapCnt = 4'h0;
   initial watchdogRefresh = 1'b0;
   // Clamp stands for an external short holding reset low
   assign resetPinIn = resetOutN & ~clampReset;
   always @(posedge clk)
   begin
      gapCnt <= gapCnt + 4'h1;
      // A controller held in reset by resetOutN cannot refresh
      watchdogRefresh <= refreshEn && resetOutN && gapCnt == 4'hF;
   end
endmodule

// ===== fail_safe_supply_supervisor_test.sv
// Self-checking bench of the supply supervisor
module fail_safe_supply_supervisor_test;
   timeunit 1ns;
   timeprecision 100ps;
   import fss_pkg::*;
   localparam int WDP = 40;
   localparam int RSTP = 4;
   logic clk = 1'b0, rstn = 1'b0, batterySupplyOneAboveStart = 1'b1;
   logic mcuSupplyUnderVoltage = 1'b0, powerOnReset = 1'b0, initToNormal = 1'b0;
   logic [1:0] debugResistorPinCode = 2'h2;
   logic holdBitWrite = 1'b0, holdBitValue = 1'b0, safeSelBitWrite = 1'b0;
   logic safeSelBitValue = 1'b0, overrideWrite = 1'b0, inputWakeEnable = 1'b0;
   logic [2:0] overrideValue = 3'h7;
   logic spiCmdValid = 1'b0, inputOne = 1'b1, refreshEn = 1'b1, clampReset = 1'b0;
   logic canBusIdle = 1'b0, canActivity = 1'b0, linActivity = 1'b0;
   logic [15:0] spiCmd = 16'h0000;
   logic watchdogRefresh, resetPinIn, mcuSupplyEnable, resetOutN, safeOutN;
   logic batteryFailFlag, holdBit, watchdogFailState;
   logic [2:0] safeBehaviourCode;
   logic [2:0] codes [4] = '{OVR_KEEP, OVR_CUT_IDLE, OVR_CUT_LOW, OVR_CUT_BOTH};
   int failures = 0, totalChecks = 0;

   fail_safe_supply_supervisor #(
      .BUS_IDLE_CYCLES(50),
      .WD_PERIOD_CYCLES(WDP),
      .RST_PULSE_CYCLES(RSTP)
   ) uut (
      .clk, .rstn, .batterySupplyOneAboveStart, .mcuSupplyUnderVoltage, .powerOnReset,
      .initToNormal, .debugResistorPinCode, .holdBitWrite, .holdBitValue, .safeSelBitWrite,
      .safeSelBitValue, .overrideWrite, .overrideValue, .inputWakeEnable, .spiCmdValid,
      .spiCmd, .watchdogRefresh, .canBusIdle, .canActivity,
      .linActivity, .inputOne, .resetPinIn, .mcuSupplyEnable, .resetOutN,
      .safeOutN, .batteryFailFlag, .holdBit, .safeBehaviourCode, .watchdogFailState
   );
   fss_mcu_model mcu (.clk, .resetOutN, .refreshEn, .clampReset, .watchdogRefresh, .resetPinIn);

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Polls at the falling edge so the value seen is settled
   task automatic waitv(ref logic s, input logic v, input int n);
      for (int i = 0; i < n && s !== v; i++)
         @(negedge clk);
      @(posedge clk);
   endtask

   task automatic wrOvr(input logic [2:0] v);
      overrideWrite <= 1'b1;
      overrideValue <= v;
      @(posedge clk);
      overrideWrite <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wrSel(input logic v);
      safeSelBitWrite <= 1'b1;
      safeSelBitValue <= v;
      @(posedge clk);
      safeSelBitWrite <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cmd(input logic [15:0] c);
      spiCmd <= c;
      spiCmdValid <= 1'b1;
      @(posedge clk);
      spiCmdValid <= 1'b0;
      cyc(2);
   endtask

   task automatic toNormal();
      initToNormal <= 1'b1;
      @(posedge clk);
      initToNormal <= 1'b0;
      cyc(2);
   endtask

   task automatic tCfg();
      toNormal();
      chk(safeBehaviourCode, OVR_CUT_LOW);
      debugResistorPinCode <= 2'h3;
      toNormal();
      chk(safeBehaviourCode, OVR_CUT_LOW);
      foreach (codes[i])
      begin
         wrOvr(codes[i]);
         chk(safeBehaviourCode, codes[i]);
      end
      wrOvr(3'h3);
      chk(safeBehaviourCode, OVR_CUT_BOTH);
      holdBitValue <= 1'b1;
      holdBitWrite <= 1'b1;
      @(posedge clk);
      holdBitWrite <= 1'b0;
      @(posedge clk);
      chk(holdBit, 1'b1);
      powerOnReset <= 1'b1;
      debugResistorPinCode <= 2'h2;
      @(posedge clk);
      powerOnReset <= 1'b0;
      cyc(2);
      chk(holdBit, 1'b0);
      chk(batteryFailFlag, 1'b1);
      chk(safeBehaviourCode, OVR_CUT_LOW);
      toNormal();
   endtask

   task automatic tWdog();
      int n;
      wrOvr(OVR_KEEP);
      wrSel(1'b1);
      refreshEn <= 1'b0;
      waitv(resetOutN, 1'b0, 80);
      for (n = 0; resetOutN === 1'b0 && n < 20; n++)
         @(posedge clk);
      chk(16'(n), 16'(RSTP));
      chk(safeOutN, 1'b1);
      waitv(resetOutN, 1'b0, 80);
      cyc(2);
      chk(safeOutN, 1'b0);
      waitv(watchdogFailState, 1'b1, 400);
      chk(watchdogFailState, 1'b1);
      cyc(5);
      chk(mcuSupplyEnable, 1'b1);
      refreshEn <= 1'b1;
      waitv(watchdogFailState, 1'b0, 100);
      chk(watchdogFailState, 1'b0);
      cmd(16'hDD01);
      chk(safeOutN, 1'b0);
      cmd(CMD_RELEASE_B);
      chk(safeOutN, 1'b1);
   endtask

   task automatic tCut();
      wrOvr(OVR_CUT_LOW);
      wrSel(1'b0);
      inputWakeEnable <= 1'b1;
      refreshEn <= 1'b0;
      waitv(resetOutN, 1'b0, 80);
      cyc(2);
      chk(safeOutN, 1'b0);
      waitv(watchdogFailState, 1'b1, 400);
      cyc(5);
      chk(mcuSupplyEnable, 1'b1);
      inputOne <= 1'b0;
      waitv(mcuSupplyEnable, 1'b0, 10);
      chk(mcuSupplyEnable, 1'b0);
      cmd(CMD_RELEASE_A);
      chk(safeOutN, 1'b0);
      inputOne <= 1'b1;
      waitv(mcuSupplyEnable, 1'b1, 10);
      chk(mcuSupplyEnable, 1'b1);
      chk(safeOutN, 1'b0);
      refreshEn <= 1'b1;
      cyc(100);
      cmd(CMD_RELEASE_A);
      chk(safeOutN, 1'b1);
   endtask

   task automatic tFault();
      clampReset <= 1'b1;
      waitv(safeOutN, 1'b0, 20);
      chk(safeOutN, 1'b0);
      clampReset <= 1'b0;
      cyc(100);
      cmd(CMD_RELEASE_B);
      chk(safeOutN, 1'b1);
      batterySupplyOneAboveStart <= 1'b0;
      cyc(3);
      chk(mcuSupplyEnable, 1'b1);
      mcuSupplyUnderVoltage <= 1'b1;
      cyc(2);
      chk(resetOutN, 1'b0);
      chk(safeOutN, 1'b0);
      waitv(mcuSupplyEnable, 1'b0, 10);
      chk(mcuSupplyEnable, 1'b0);
      batterySupplyOneAboveStart <= 1'b1;
      mcuSupplyUnderVoltage <= 1'b0;
      waitv(mcuSupplyEnable, 1'b1, 10);
      chk(mcuSupplyEnable, 1'b1);
   endtask

   task automatic tIdle();
      cmd(CMD_RELEASE_A);
      chk(safeOutN, 1'b1);
      wrOvr(OVR_CUT_BOTH);
      inputWakeEnable <= 1'b0;
      canBusIdle <= 1'b1;
      refreshEn <= 1'b0;
      waitv(watchdogFailState, 1'b1, 400);
      cyc(20);
      chk(mcuSupplyEnable, 1'b1);
      cyc(40);
      chk(mcuSupplyEnable, 1'b1);
      wrOvr(OVR_CUT_IDLE);
      waitv(mcuSupplyEnable, 1'b0, 10);
      chk(mcuSupplyEnable, 1'b0);
      cyc(10);
      chk(mcuSupplyEnable, 1'b0);
      canActivity <= 1'b1;
      @(posedge clk);
      canActivity <= 1'b0;
      waitv(mcuSupplyEnable, 1'b1, 10);
      chk(mcuSupplyEnable, 1'b1);
      canBusIdle <= 1'b0;
      refreshEn <= 1'b1;
      cyc(100);
      cmd(CMD_RELEASE_B);
      chk(safeOutN, 1'b1);
   endtask

   task automatic end_sim();
      $display("Checks %0d, failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      cyc(4);
      chk(holdBit, 1'b0);
      chk(safeOutN, 1'b1);
      tCfg();
      tWdog();
      tCut();
      tFault();
      tIdle();
      end_sim();
   end

   // Whole run needs about 1500 cycles
   initial
   begin
      #(25 * 20000);
      failures++;
      end_sim();
   end
endmodule
